// ==== inc/pee_pkg.sv ====
// pee_pkg: constants for the host-side controller of a 2048 x 8 parallel eeprom
// assumes a 20 MHz system clock; device timing except T_OE_NS and T_PROG_MAX_US is converted to cycles here
package pee_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    // ----------------------------------------------------------------
    // device timing, in units as printed
    // ----------------------------------------------------------------
    localparam int T_ACC_NS = 450;       // address/enable to data valid
    localparam int T_OE_NS = 120;        // output enable to data valid
    localparam int T_VFY_NS = 150;       // verify output enable to data
    localparam int T_OFF_NS = 100;       // output disable to high z
    localparam int T_SETUP_NS = 2000;    // setup and hold around a pulse
    localparam int T_PROG_MIN_US = 1000;
    localparam int T_PROG_MAX_US = 10000;
    localparam int T_ERASE_US = 100000;
    // ----------------------------------------------------------------
    // derived cycle counts: least times round up
    // ----------------------------------------------------------------
    localparam int NS_PER_CLK = 1_000_000_000 / CLK_HZ;
    localparam int CYC_ACC = (T_ACC_NS + NS_PER_CLK - 1) / NS_PER_CLK + 1;
    localparam int CYC_VFY = (T_VFY_NS + NS_PER_CLK - 1) / NS_PER_CLK + 1;
    localparam int CYC_OFF = (T_OFF_NS + NS_PER_CLK - 1) / NS_PER_CLK;
    localparam int CYC_SETUP = (T_SETUP_NS + NS_PER_CLK - 1) / NS_PER_CLK;
    localparam int CYC_PROG_DEF = T_PROG_MIN_US * (CLK_HZ / 1_000_000) * 5;
    localparam int CYC_ERASE_DEF = T_ERASE_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W = 22;
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;

    typedef enum logic [1:0] {
        PEE_OP_READ,
        PEE_OP_PROG,
        PEE_OP_ERASE
    } pee_op_t;
endpackage

// ==== verilog/pee_timer.sv ====
// pee_timer: loadable down counter with a one-cycle done pulse
// assumes a caller that loads a nonzero count and waits for done
`timescale 1ns/1ns
module pee_timer
    import pee_pkg::*;
(
    input wire logic clk,                  // system clock
    input wire logic rst,                  // async reset, active high
    input wire logic load,                 // load pulse
    input wire logic [CNT_W-1:0] count,    // cycles to wait, at least 1
    output logic done                      // one-cycle pulse at expiry
);
    logic [CNT_W-1:0] cnt_reg;
    logic run_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (load) begin
                cnt_reg <= count;
                run_reg <= 1'b1;
            end else if (run_reg) begin
                if (cnt_reg <= CNT_W'(1)) begin
                    run_reg <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - CNT_W'(1);
                end
            end
        end
    end
endmodule

// ==== verilog/pee_host.sv ====
// pee_host: host controller driving a 2048 x 8 parallel eeprom through its pins
// assumes a single device on the bus, high-voltage switch driven by vpp_hi
// Behaviour
// - host asserts output enable on at most one shared device
// - program with 25 V supply, output enable high, byte on all pins
// - one enable pulse per address, between 1 ms and 10 ms
// - host never holds enable high steadily as a program pulse
// - oe high, address, data stable 2 us before and after pulse
// - parallel devices share all inputs except enable pins
// - verify by read with 25 V supply, data within 150 ns of oe
// - erase: 25 V supply, oe low, 100 ms enable pulse, array all ones
// - supply 25 V for program, verify, inhibit, erase; low otherwise
`timescale 1ns/1ns
module pee_host
    import pee_pkg::*;
#(
    parameter int CYC_PROG = CYC_PROG_DEF,     // program pulse, 1 ms..10 ms
    parameter int CYC_ERASE = CYC_ERASE_DEF    // erase pulse
) (
    input wire logic clk,                      // 20 MHz clock
    input wire logic rst,                      // async reset, active high
    input wire logic req_valid,                // request strobe
    input wire pee_op_t req_op,                // read, program or erase
    input wire logic [ADDR_W-1:0] req_addr,    // byte address
    input wire logic [DATA_W-1:0] req_wdata,   // byte to program
    output logic req_ready,                    // idle, request accepted
    output logic rsp_valid,                    // one-cycle done pulse
    output logic [DATA_W-1:0] rsp_rdata,       // read or verify byte
    output logic rsp_err,                      // verify mismatch
    output logic [ADDR_W-1:0] mem_addr,        // address pins
    output logic [DATA_W-1:0] mem_dq_o,        // data pins out
    output logic mem_dq_oe,                    // high while host drives data
    input wire logic [DATA_W-1:0] mem_dq_i,    // data pins in
    output logic mem_ce_prog_n,                // combined enable / program, one per device
    output logic mem_oe_n,                     // output enable, active low
    output logic vpp_hi                        // switch supply to 25 V
);
    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE, S_RD, S_VPP_UP, S_SETUP, S_PULSE, S_HOLD,
        S_VFY, S_OFF, S_VPP_DN
    } pee_state_t;

    pee_state_t state_reg;
    pee_op_t op_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic tmr_load;
    logic [CNT_W-1:0] tmr_count;
    logic tmr_done;

    // expected value after a program: only zeros land on the cells
    function automatic logic [DATA_W-1:0] expect_byte(input pee_op_t op,
                                                      input logic [DATA_W-1:0] d);
        expect_byte = (op == PEE_OP_ERASE) ? ERASED_BYTE : d;
    endfunction

    pee_timer u_tmr (
        .clk(clk),
        .rst(rst),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    // timer loads on every state entry except the return to S_IDLE; count chosen by the state entered
    always_comb begin
        tmr_load = 1'b0;
        tmr_count = CNT_W'(CYC_SETUP);
        case (state_reg)
            S_IDLE: begin
                tmr_load = req_valid;
                tmr_count = (req_op == PEE_OP_READ) ? CNT_W'(CYC_ACC) : CNT_W'(CYC_SETUP);
            end
            S_VPP_UP: begin
                tmr_load = tmr_done;
            end
            S_SETUP: begin
                tmr_load = tmr_done;
                tmr_count = (op_reg == PEE_OP_ERASE) ? CNT_W'(CYC_ERASE) : CNT_W'(CYC_PROG);
            end
            S_PULSE: begin
                tmr_load = tmr_done;
            end
            S_HOLD: begin
                tmr_load = tmr_done;
                tmr_count = CNT_W'(CYC_VFY);
            end
            S_VFY: begin
                tmr_load = tmr_done;
                tmr_count = CNT_W'(CYC_OFF + 1);
            end
            S_OFF: begin
                tmr_load = tmr_done;
            end
            default: begin
                tmr_load = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= S_IDLE;
            op_reg <= PEE_OP_READ;
            wdata_reg <= '0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (req_valid) begin
                        op_reg <= req_op;
                        wdata_reg <= req_wdata;
                        state_reg <= (req_op == PEE_OP_READ) ? S_RD : S_VPP_UP;
                    end
                end
                S_RD: if (tmr_done) state_reg <= S_IDLE;
                S_VPP_UP: if (tmr_done) state_reg <= S_SETUP;
                S_SETUP: if (tmr_done) state_reg <= S_PULSE;
                S_PULSE: if (tmr_done) state_reg <= S_HOLD;
                S_HOLD: if (tmr_done) state_reg <= S_VFY;
                S_VFY: if (tmr_done) state_reg <= S_OFF;
                S_OFF: if (tmr_done) state_reg <= S_VPP_DN;
                S_VPP_DN: if (tmr_done) state_reg <= S_IDLE;
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_addr <= '0;
            mem_dq_o <= '0;
            mem_dq_oe <= 1'b0;
            mem_ce_prog_n <= 1'b1;
            mem_oe_n <= 1'b1;
            vpp_hi <= 1'b0;
        end else begin
            if (state_reg == S_IDLE && req_valid) begin
                mem_addr <= req_addr;
                mem_dq_o <= req_wdata;
                // erase needs oe low; program wants it high with data driven
                mem_oe_n <= (req_op == PEE_OP_PROG);
                mem_dq_oe <= (req_op == PEE_OP_PROG);
                // enable low: read, or inhibit while the supply ramps
                mem_ce_prog_n <= 1'b0;
                vpp_hi <= 1'b0;
            end
            case (state_reg)
                S_RD: if (tmr_done) begin
                    mem_oe_n <= 1'b1;
                    mem_ce_prog_n <= 1'b1;
                end
                S_VPP_UP: if (tmr_done) vpp_hi <= 1'b1;
                S_SETUP: if (tmr_done) mem_ce_prog_n <= 1'b1;
                // pulse ends on the timer, never a steady high
                S_PULSE: if (tmr_done) mem_ce_prog_n <= 1'b0;
                S_HOLD: if (tmr_done) begin
                    mem_dq_oe <= 1'b0;
                    mem_oe_n <= 1'b0;
                end
                S_VFY: if (tmr_done) mem_oe_n <= 1'b1;
                S_OFF: if (tmr_done) vpp_hi <= 1'b0;
                // enable held low 2 us past supply fall, no stray pulse
                S_VPP_DN: if (tmr_done) mem_ce_prog_n <= 1'b1;
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // answers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_ready <= 1'b1;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            rsp_err <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            if (state_reg == S_IDLE && req_valid) req_ready <= 1'b0;
            if (state_reg == S_RD && tmr_done) begin
                rsp_rdata <= mem_dq_i;
                rsp_err <= 1'b0;
                rsp_valid <= 1'b1;
                req_ready <= 1'b1;
            end
            if (state_reg == S_VFY && tmr_done) begin
                rsp_rdata <= mem_dq_i;
                rsp_err <= (mem_dq_i != expect_byte(op_reg, wdata_reg));
            end
            if (state_reg == S_VPP_DN && tmr_done) begin
                rsp_valid <= 1'b1;
                req_ready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    int unsigned hi_cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) hi_cnt <= 0;
        else if (!mem_ce_prog_n && vpp_hi) hi_cnt <= 0;
        else if (mem_ce_prog_n && vpp_hi) hi_cnt <= hi_cnt + 1;
        else hi_cnt <= 0;
    end

    a_pulse_bounded: assert property (@(posedge clk) disable iff (rst)
        hi_cnt <= CYC_ERASE + 2) else $error("enable pulse too long");
    a_prog_oe_high: assert property (@(posedge clk) disable iff (rst)
        (vpp_hi && op_reg == PEE_OP_PROG && mem_ce_prog_n) |-> mem_oe_n)
        else $error("oe low during program pulse");
    a_erase_oe_low: assert property (@(posedge clk) disable iff (rst)
        (vpp_hi && op_reg == PEE_OP_ERASE && mem_ce_prog_n) |-> !mem_oe_n)
        else $error("oe high during erase pulse");
    a_no_contention: assert property (@(posedge clk) disable iff (rst)
        !(mem_dq_oe && !mem_oe_n)) else $error("bus contention");
    a_addr_stable: assert property (@(posedge clk) disable iff (rst)
        (state_reg != S_IDLE) |=> $stable(mem_addr))
        else $error("address moved during cycle");
    a_vpp_pulse: assert property (@(posedge clk) disable iff (rst)
        $rose(mem_ce_prog_n) && state_reg == S_PULSE |-> vpp_hi)
        else $error("pulse without high supply");
    a_read_low_vpp: assert property (@(posedge clk) disable iff (rst)
        (state_reg == S_RD) |-> !vpp_hi) else $error("high supply on read");
    a_read_time: assert property (@(posedge clk) disable iff (rst)
        (state_reg == S_IDLE && req_valid && req_op == PEE_OP_READ)
        |-> ##[12:14] rsp_valid) else $error("read answer late");

    c_read: cover property (@(posedge clk) rsp_valid && op_reg == PEE_OP_READ);
    c_prog: cover property (@(posedge clk) rsp_valid && op_reg == PEE_OP_PROG);
    c_erase: cover property (@(posedge clk) rsp_valid && op_reg == PEE_OP_ERASE);
    c_vfy_err: cover property (@(posedge clk) rsp_valid && rsp_err);
endmodule

// ==== sim/pee_dev_model.sv ====
// pee_dev_model: behavioural 2048 x 8 eeprom seen from its pins
// assumes one host on the pins; pulse limits scaled to the bench's short pulses
`timescale 1ns/1ns
module pee_dev_model
    import pee_pkg::*;
#(
    parameter int PULSE_MIN_NS = 1000000, // shortest legal program pulse
    parameter int PULSE_MAX_NS = 10000000 // longest legal program pulse
) (
    input wire logic [ADDR_W-1:0] addr, // address pins
    input wire logic [DATA_W-1:0] dq_in, // byte driven by host
    input wire logic dq_oe, // host drives data
    output logic [DATA_W-1:0] dq_out, // byte driven by device
    input wire logic ce_prog_n, // combined enable / program
    input wire logic oe_n, // output enable
    input wire logic vpp_hi, // supply at 25 V
    output logic fault // sticky host timing fault
);
    logic [DATA_W-1:0] mem [0:2047];
    logic [DATA_W-1:0] last_q;
    realtime t_addr, t_data, t_vpp, t_rise, t_fall;
    wire rd_on = !ce_prog_n && !oe_n;
    initial begin
        for (int i = 0; i < 2048; i++) mem[i] = 8'(i) ^ 8'h5A;
        fault = 1'b0;
        last_q = 8'h00;
        t_addr = 0; t_data = 0; t_vpp = 0; t_rise = 0; t_fall = 0;
    end
    // --------------------------------------------------------------
    // read path
    // --------------------------------------------------------------
    // released lines show the inverse of the last byte, never a stale copy
    always @* if (rd_on) last_q = mem[addr];
    assign #100 dq_out = rd_on ? mem[addr] : ~last_q;
    // --------------------------------------------------------------
    // program and erase
    // --------------------------------------------------------------
    always @(addr) begin
        if (t_fall > 0 && $realtime - t_fall < 2000) fault = 1'b1;
        t_addr = $realtime;
    end
    always @(dq_in) t_data = $realtime;
    always @(posedge vpp_hi) t_vpp = $realtime;
    always @(posedge ce_prog_n) begin
        if (vpp_hi === 1'b1) begin
            t_rise = $realtime;
            if ($realtime - t_addr < 2000 || $realtime - t_vpp < 2000) fault = 1'b1;
            if (oe_n && (!dq_oe || $realtime - t_data < 2000)) fault = 1'b1;
        end
    end
    // writes land only on a pulse end; enable held low never programs
    always @(negedge ce_prog_n) begin
        if (vpp_hi !== 1'b1) begin
            if (t_rise > 0) fault = 1'b1;
        end else if (t_rise > 0) begin
            t_fall = $realtime;
            if ($realtime - t_rise < PULSE_MIN_NS) fault = 1'b1;
            if (oe_n) begin
                if ($realtime - t_rise > PULSE_MAX_NS) fault = 1'b1;
                mem[addr] = mem[addr] & dq_in;
            end else begin
                for (int i = 0; i < 2048; i++) mem[i] = ERASED_BYTE;
            end
        end
        t_rise = 0;
    end
endmodule

// ==== sim/tb_top.sv ====
// tb_top: self-checking bench for the eeprom host controller
// assumes shortened pulse parameters and the pin model in pee_dev_model
`timescale 1ns/1ns
module tb_top;
    import pee_pkg::*;
    localparam int PROG_CYC = 50;
    localparam int ERASE_CYC = 80;
    logic clk, rst, req_valid, req_ready, rsp_valid, rsp_err;
    logic mem_dq_oe, mem_ce_prog_n, mem_oe_n, vpp_hi, dev_fault;
    pee_op_t req_op;
    logic [ADDR_W-1:0] req_addr, mem_addr;
    logic [DATA_W-1:0] req_wdata, rsp_rdata, mem_dq_o, mem_dq_i;
    int fails, n_compared, cyc, lat;
    pee_host #(.CYC_PROG(PROG_CYC), .CYC_ERASE(ERASE_CYC)) dut (
        .clk(clk), .rst(rst), .req_valid(req_valid), .req_op(req_op),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err),
        .mem_addr(mem_addr), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe),
        .mem_dq_i(mem_dq_i), .mem_ce_prog_n(mem_ce_prog_n), .mem_oe_n(mem_oe_n),
        .vpp_hi(vpp_hi));
    pee_dev_model #(.PULSE_MIN_NS(PROG_CYC * 10), .PULSE_MAX_NS(PROG_CYC * 100)) dev (
        .addr(mem_addr), .dq_in(mem_dq_o), .dq_oe(mem_dq_oe), .dq_out(mem_dq_i),
        .ce_prog_n(mem_ce_prog_n), .oe_n(mem_oe_n), .vpp_hi(vpp_hi), .fault(dev_fault));
    // --------------------------------------------------------------
    // shared helpers
    // --------------------------------------------------------------
    task automatic check(input logic ok, input string what);
        n_compared++;
        if (ok !== 1'b1) begin
            fails++;
            $display("CHECK FAILED t=%0t %s", $time, what);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // one request, waits for the answer; idle pins and supply checked after it
    task automatic run_op(input pee_op_t op, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
        @(posedge clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk);
        req_valid <= 1'b0;
        lat = 0;
        do begin
            @(negedge clk);
            lat++;
            if (op == PEE_OP_READ && vpp_hi !== 1'b0) check(1'b0, "supply raised in read");
            if (lat == 1 && req_ready !== 1'b0) check(1'b0, "ready high while busy");
        end while (rsp_valid !== 1'b1 && lat < 3000);
        check(rsp_valid === 1'b1, "no answer");
        check(req_ready === 1'b1, "ready not back with answer");
        check(mem_oe_n === 1'b1 && mem_ce_prog_n === 1'b1, "pins not idle");
        check(vpp_hi === 1'b0 && dev_fault === 1'b0, "supply or pin timing fault");
    endtask
    task automatic expect_rsp(input logic [DATA_W-1:0] d, input logic e, input string what);
        check(rsp_rdata === d && rsp_err === e, what);
    endtask
    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_reset_pins();
        check(mem_ce_prog_n === 1'b1 && mem_oe_n === 1'b1, "enables not idle");
        check(mem_dq_oe === 1'b0 && vpp_hi === 1'b0, "data or supply active");
    endtask
    task automatic t_read_timing();
        run_op(PEE_OP_READ, 11'h003, 8'h00);
        check(lat == CYC_ACC + 2, "read latency");
        expect_rsp(8'h03 ^ 8'h5A, 1'b0, "read of preset byte");
    endtask
    // unerased byte: program can only clear bits, so verify must flag it
    task automatic t_program_unerased();
        run_op(PEE_OP_PROG, 11'h010, 8'h3C);
        expect_rsp(8'h4A & 8'h3C, 1'b1, "program over unerased byte");
    endtask
    task automatic t_erase_all();
        run_op(PEE_OP_ERASE, 11'h000, 8'h00);
        check(rsp_err === 1'b0, "erase verify");
        run_op(PEE_OP_READ, 11'h7FF, 8'h00);
        expect_rsp(ERASED_BYTE, 1'b0, "top byte after erase");
    endtask
    task automatic t_program_pair();
        run_op(PEE_OP_PROG, 11'h010, 8'h3C);
        expect_rsp(8'h3C, 1'b0, "program erased byte");
        run_op(PEE_OP_PROG, 11'h010, 8'hF0);
        expect_rsp(8'h30, 1'b1, "ones not restored");
    endtask
    task automatic t_read_back_to_back();
        run_op(PEE_OP_READ, 11'h010, 8'h00);
        expect_rsp(8'h30, 1'b0, "programmed byte");
        run_op(PEE_OP_READ, 11'h000, 8'h00);
        expect_rsp(ERASED_BYTE, 1'b0, "bottom byte");
    endtask
    // --------------------------------------------------------------
    // clock, timeout, main sequence
    // --------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // all ops together take about a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req_op = PEE_OP_READ;
        req_addr = 11'h000;
        req_wdata = 8'h00;
        fails = 0;
        n_compared = 0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        t_reset_pins();
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_read_timing();
        t_program_unerased();
        t_erase_all();
        t_program_pair();
        t_read_back_to_back();
        end_sim();
    end
endmodule
